// File: rtl/program_memory_bank_extension.sv
`timescale 1ns/1ns
// What this block does
// - after reset fetch starts at address 0000 in bank zero.
// - program space is eight 64 Kbyte banks selected by three address bits above the 16-bit pc.
// - setting next, interrupt and movc bank bits to one then a long jump frees the top pins.
// - each shared port pin outputs its upper address bit (current bank, or movc bank on movc reads with memory mode one) anded with its port latch.
// - reset clears current bank bits and sets port latches to one so the pins show zero.
// - current bank is read only and takes next bank on each long jump.
// - with indirect jump banking enabled an indirect jump acts like a long jump.
// - select register holds current bank in bits 6:4 and next bank in bits 2:0, resets to x000x000.
// - mode register holds memory mode, movc bank, stack full and interrupt bank, resets to 00.
// - code constant reads use current bank when memory mode is zero, else movc bank.
// - a call pushes both bank fields, bumps the pointer, then copies next into current.
// - a return pops the pointer and restores both bank fields.
// - an interrupt pushes both fields then loads both from the interrupt bank bits.
// - reset clears memory mode, movc bank and interrupt bank bits.
// - stack full is set whenever a bank stack overflow is imminent.
module program_memory_bank_extension
  import code_bank_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH
)
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             srst,
  // sequencer events and fetch kind
  input  wire xfer_t            xfer,
  input  wire logic             code_const_read,
  input  wire logic             indirect_jump_banking_enable,
  // special function register bus
  input  wire sfr_wr_t          sfr,
  input  wire logic [7:0]       sfr_raddr,
  output logic [7:0]            sfr_rdata,
  // port latches shared with upper pins
  input  wire logic             port_latch_wr,
  input  wire logic [1:0]       port_latch_wdata,
  // address outputs
  output logic [BANK_W-1:0]     prog_addr_hi,
  output logic [1:0]            port_four_pin,
  output logic [15:0]           reset_vector
);

  localparam int PW = $clog2(DEPTH) + 1;
  localparam logic [PW-1:0] PTR_ONE  = PW'(1);
  localparam logic [PW-1:0] FULL_LVL = PW'(DEPTH - 1);
  localparam logic [1:0]    LATCH_ONES = 2'h3; // both shared pins in address mode

  logic [2:0]    current_bank_reg, current_bank_next;
  logic [2:0]    next_bank_reg, next_bank_next;
  logic          memory_mode_reg;
  logic [2:0]    movc_bank_reg, interrupt_bank_reg;
  logic [1:0]    port_four_latch_reg;
  logic [PW-1:0] ptr_reg, ptr_next;
  logic          stack_full_reg;
  logic [PW-1:0] chk_depth_reg;
  bank_pair_t    stack_mem [DEPTH];

  // bank stack slot, the pointer without its top bit; only the pointer holds the full count
  function automatic logic [PW-2:0] slot(input logic [PW-1:0] p);
    return p[PW-2:0];
  endfunction

  // event decode; interrupt outranks call, call outranks return
  wire jump_take = xfer.long_jump | (xfer.indirect_jump & indirect_jump_banking_enable);
  wire push_take = xfer.irq | xfer.call;
  wire pop_take  = xfer.ret & ~push_take & (ptr_reg != '0);
  wire sel_wr    = sfr.wr & (sfr.addr == SELECT_ADDR);
  wire mode_wr   = sfr.wr & (sfr.addr == MODE_ADDR);
  wire [PW-1:0] ptr_dec = ptr_reg - PTR_ONE;
  wire bank_pair_t popped = stack_mem[slot(ptr_dec)];

  // bank field next values; a push saves the old pair before the copy
  always_comb
  begin
    current_bank_next = current_bank_reg;
    next_bank_next    = sel_wr ? sfr.wdata[NEXT_LSB +: BANK_W] : next_bank_reg;
    ptr_next          = ptr_reg;
    if (xfer.irq)
    begin
      current_bank_next = interrupt_bank_reg;
      next_bank_next    = interrupt_bank_reg;
      ptr_next          = ptr_reg + PTR_ONE;
    end
    else if (xfer.call)
    begin
      current_bank_next = next_bank_reg;
      ptr_next          = ptr_reg + PTR_ONE;
    end
    else if (pop_take)
    begin
      current_bank_next = popped.cur;
      next_bank_next    = popped.nxt;
      ptr_next          = ptr_dec;
    end
    else if (jump_take)
      current_bank_next = next_bank_reg;
  end

  // bank state; current bank never takes a software write
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      current_bank_reg <= BANK_ZERO;
      next_bank_reg    <= BANK_ZERO;
      ptr_reg          <= '0;
    end
    else
    begin
      current_bank_reg <= current_bank_next;
      next_bank_reg    <= next_bank_next;
      ptr_reg          <= ptr_next;
    end
  end

  // stack storage; pushes past the top are dropped, stack full warns first
  always_ff @(posedge core_clk)
  begin
    if (push_take && ptr_reg < PW'(DEPTH))
      stack_mem[slot(ptr_reg)] <= '{cur: current_bank_reg, nxt: next_bank_reg};
  end

  // mode register; the stack full bit is hardware owned
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      memory_mode_reg    <= MODE_RESET[MM_BIT];
      movc_bank_reg      <= MODE_RESET[MB_LSB +: BANK_W];
      interrupt_bank_reg <= MODE_RESET[IB_LSB +: BANK_W];
    end
    else if (mode_wr)
    begin
      memory_mode_reg    <= sfr.wdata[MM_BIT];
      movc_bank_reg      <= sfr.wdata[MB_LSB +: BANK_W];
      interrupt_bank_reg <= sfr.wdata[IB_LSB +: BANK_W];
    end
  end

  // stack full tracks the next pointer so it is valid with the level
  always_ff @(posedge core_clk)
  begin
    if (srst)
      stack_full_reg <= MODE_RESET[SF_BIT];
    else
      stack_full_reg <= (ptr_next >= FULL_LVL);
  end

  // port latches reset high so the shared pins follow the bank bits
  always_ff @(posedge core_clk)
  begin
    if (srst)
      port_four_latch_reg <= LATCH_ONES;
    else if (port_latch_wr)
      port_four_latch_reg <= port_latch_wdata;
  end

  // upper address; registered from the next bank value, so it changes on the same edge as the bank registers
  wire [2:0] addr_hi_next = (code_const_read && memory_mode_reg) ? movc_bank_reg
                                                                  : current_bank_next;
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      prog_addr_hi  <= BANK_ZERO;
      port_four_pin <= 2'h0;
      reset_vector  <= RESET_PC;
    end
    else
    begin
      prog_addr_hi  <= addr_hi_next;
      port_four_pin <= addr_hi_next[2:1] & port_four_latch_reg;
      reset_vector  <= RESET_PC;
    end
  end

  // register read mux; unused bits read as zero
  wire [7:0] sel_val  = {1'b0, current_bank_reg, 1'b0, next_bank_reg};
  wire [7:0] mode_val = {memory_mode_reg, movc_bank_reg, stack_full_reg, interrupt_bank_reg};
  always_ff @(posedge core_clk)
  begin
    if (srst)
      sfr_rdata <= 8'h00;
    else
      sfr_rdata <= (sfr_raddr == SELECT_ADDR) ? sel_val :
                   (sfr_raddr == MODE_ADDR)   ? mode_val : 8'h00;
  end

  // checks
  // independent depth count, so the full flag is not checked against its own pointer
  always_ff @(posedge core_clk)
  begin
    if (srst)
      chk_depth_reg <= '0;
    else if (push_take)
      chk_depth_reg <= chk_depth_reg + PTR_ONE;
    else if (xfer.ret && chk_depth_reg != '0)
      chk_depth_reg <= chk_depth_reg - PTR_ONE;
  end

  sequence s_call;
    xfer.call && !xfer.irq;
  endsequence

  sequence s_ret;
    xfer.ret && !push_take && !sel_wr;
  endsequence

  property p_jump_copy;
    @(posedge core_clk) disable iff (srst)
    (jump_take && !push_take && !pop_take) |=> current_bank_reg == $past(next_bank_reg);
  endproperty
  a_jump_copy: assert property (p_jump_copy) else $error("jump did not copy next bank");

  property p_call_push;
    @(posedge core_clk) disable iff (srst)
    s_call |=> (ptr_reg == $past(ptr_reg) + PTR_ONE) && current_bank_reg == $past(next_bank_reg);
  endproperty
  a_call_push: assert property (p_call_push) else $error("call push wrong");

  property p_irq_load;
    @(posedge core_clk) disable iff (srst)
    xfer.irq |=> current_bank_reg == $past(interrupt_bank_reg)
                 && next_bank_reg == $past(interrupt_bank_reg);
  endproperty
  a_irq_load: assert property (p_irq_load) else $error("interrupt bank not loaded");

  property p_call_ret;
    @(posedge core_clk) disable iff (srst)
    (s_call ##1 s_ret) |=>
      current_bank_reg == $past(current_bank_reg, 2);
  endproperty
  a_call_ret: assert property (p_call_ret) else $error("return did not restore bank");

  property p_ret_next;
    @(posedge core_clk) disable iff (srst)
    (s_call ##1 s_ret) |=> next_bank_reg == $past(next_bank_reg, 2);
  endproperty
  a_ret_next: assert property (p_ret_next) else $error("next bank not restored");

  property p_pop_empty;
    @(posedge core_clk) disable iff (srst)
    (xfer.ret && !push_take && !jump_take && !sel_wr && ptr_reg == '0) |=>
      $stable(current_bank_reg) && $stable(next_bank_reg) && ptr_reg == '0;
  endproperty
  a_pop_empty: assert property (p_pop_empty) else $error("empty return moved the bank");

  property p_full_flag;
    @(posedge core_clk) disable iff (srst)
    ##1 stack_full_reg == (chk_depth_reg >= FULL_LVL);
  endproperty
  a_full_flag: assert property (p_full_flag) else $error("stack full flag wrong");

  property p_pin_and;
    @(posedge core_clk) disable iff (srst)
    ##1 port_four_pin == (prog_addr_hi[2:1] & $past(port_four_latch_reg));
  endproperty
  a_pin_and: assert property (p_pin_and) else $error("port pin not bank and latch");

  property p_movc_sel;
    @(posedge core_clk) disable iff (srst)
    (code_const_read && memory_mode_reg) |=> prog_addr_hi == $past(movc_bank_reg);
  endproperty
  a_movc_sel: assert property (p_movc_sel) else $error("movc bank not driven");

  property p_cur_out;
    @(posedge core_clk) disable iff (srst)
    !(code_const_read && memory_mode_reg) |=> prog_addr_hi == current_bank_reg;
  endproperty
  a_cur_out: assert property (p_cur_out) else $error("current bank not driven");

  property p_cur_ro;
    @(posedge core_clk) disable iff (srst)
    (sel_wr && !jump_take && !push_take && !pop_take) |=> $stable(current_bank_reg);
  endproperty
  a_cur_ro: assert property (p_cur_ro) else $error("current bank took a write");

  property p_reset;
    @(posedge core_clk)
    srst |=> current_bank_reg == BANK_ZERO && ptr_reg == '0 && port_four_latch_reg == LATCH_ONES
             && !memory_mode_reg;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");

  property p_out_reset;
    @(posedge core_clk)
    srst |=> prog_addr_hi == BANK_ZERO && port_four_pin == 2'h0 && reset_vector == RESET_PC;
  endproperty
  a_out_reset: assert property (p_out_reset) else $error("outputs not cleared by reset");

  property p_sel_read;
    @(posedge core_clk) disable iff (srst)
    (sfr_raddr == SELECT_ADDR) |=>
      sfr_rdata == {1'b0, $past(current_bank_reg), 1'b0, $past(next_bank_reg)};
  endproperty
  a_sel_read: assert property (p_sel_read) else $error("select register read wrong");

  property p_mode_read;
    @(posedge core_clk) disable iff (srst)
    (sfr_raddr == MODE_ADDR) |=>
      sfr_rdata == {$past(memory_mode_reg), $past(movc_bank_reg),
                    $past(stack_full_reg), $past(interrupt_bank_reg)};
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("mode register read wrong");

endmodule

// File: rtl/code_bank_pkg.sv
package code_bank_pkg;

  // special function register addresses
  localparam logic [7:0] SELECT_ADDR = 8'h94;
  localparam logic [7:0] MODE_ADDR   = 8'h95;

  // field positions in the select register
  localparam int CUR_LSB  = 4;
  localparam int NEXT_LSB = 0;

  // field positions in the mode register
  localparam int MM_BIT   = 7;
  localparam int MB_LSB   = 4;
  localparam int SF_BIT   = 3;
  localparam int IB_LSB   = 0;

  // widths and reset values
  localparam int BANK_W = 3;
  localparam logic [2:0] BANK_ZERO  = 3'h0;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [15:0] RESET_PC  = 16'h0000;
  localparam int STACK_DEPTH = 32;

  // bank pair saved on the bank stack
  typedef struct packed {
    logic [2:0] cur;
    logic [2:0] nxt;
  } bank_pair_t;

  // control transfer events from the instruction sequencer
  typedef struct packed {
    logic long_jump;
    logic indirect_jump;
    logic call;
    logic ret;
    logic irq;
  } xfer_t;

  // special function register access strobes
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_wr_t;

endpackage

// File: sim/sequencer_model.sv
`timescale 1ns/1ns
// sequencer stand-in, one pulse per transfer
module sequencer_model
  import code_bank_pkg::*;
(
  // clock
  input  wire logic core_clk,
  // transfer events
  output xfer_t     xfer
);
  initial xfer = '0;
  // launched on the falling edge so exactly one rising edge sees it
  task automatic fire(input int k);
    @(negedge core_clk);
    xfer = xfer_t'(5'h01 << k);
    @(negedge core_clk);
    xfer = '0;
  endtask
  // two transfers on consecutive cycles, no idle cycle between them
  task automatic fire_pair(input int k1, input int k2);
    @(negedge core_clk);
    xfer = xfer_t'(5'h01 << k1);
    @(negedge core_clk);
    xfer = xfer_t'(5'h01 << k2);
    @(negedge core_clk);
    xfer = '0;
  endtask
endmodule

// File: sim/program_memory_bank_extension_test.sv
`timescale 1ns/1ns
module program_memory_bank_extension_test;
  import code_bank_pkg::*;
  localparam int LJ = 4;
  localparam int IJ = 3;
  localparam int CL = 2;
  localparam int RT = 1;
  localparam int IQ = 0;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  xfer_t       xfer;
  logic        ccr = 1'b0;
  logic        ij_en = 1'b0;
  sfr_wr_t     sfr = '0;
  logic [7:0]  sfr_raddr = 8'h00;
  logic [7:0]  sfr_rdata;
  logic        lat_wr = 1'b0;
  logic [1:0]  lat_d = 2'h3;
  logic [2:0]  prog_addr_hi;
  logic [1:0]  port_four_pin;
  logic [15:0] reset_vector;
  int          fails = 0;
  int          cmp_count = 0;
  // clock
  always #5 core_clk = ~core_clk;
  sequencer_model sequencer_model_i (.core_clk(core_clk), .xfer(xfer));
  program_memory_bank_extension program_memory_bank_extension_i (
    .core_clk(core_clk), .srst(srst), .xfer(xfer), .code_const_read(ccr),
    .indirect_jump_banking_enable(ij_en), .sfr(sfr), .sfr_raddr(sfr_raddr),
    .sfr_rdata(sfr_rdata), .port_latch_wr(lat_wr), .port_latch_wdata(lat_d),
    .prog_addr_hi(prog_addr_hi), .port_four_pin(port_four_pin),
    .reset_vector(reset_vector));
  // compare helpers
  task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_out(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // register access: strobe for one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    sfr = '{1'b1, a, d};
    @(negedge core_clk);
    sfr.wr = 1'b0;
  endtask
  // read data is registered, so look one cycle after the address
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    sfr_raddr = a;
    @(negedge core_clk);
    check_reg(sfr_rdata, exp);
  endtask
  // port latch write, pins settle two edges later
  task automatic latch(input logic [1:0] d, input logic [1:0] exp);
    @(negedge core_clk);
    lat_wr = 1'b1;
    lat_d = d;
    @(negedge core_clk);
    lat_wr = 1'b0;
    @(negedge core_clk);
    check_out(16'(port_four_pin), 16'(exp));
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog, the sequence needs well under 1000 cycles
  initial
  begin
    #20000;
    fails++;
    complete_run();
  end
  // main sequence
  initial
  begin
    repeat (8) @(negedge core_clk);
    srst = 1'b0;
    rd(SELECT_ADDR, 8'h00);
    rd(MODE_ADDR, 8'h00);
    check_out(16'(prog_addr_hi), 16'h0000);
    check_out(16'(port_four_pin), 16'h0000);
    check_out(reset_vector, 16'h0000);
    wr(SELECT_ADDR, 8'hf5);
    rd(SELECT_ADDR, 8'h05);
    sequencer_model_i.fire(LJ);
    rd(SELECT_ADDR, 8'h55);
    check_out(16'(prog_addr_hi), 16'h0005);
    check_out(16'(port_four_pin), 16'h0002);
    latch(2'h1, 2'h0);
    wr(SELECT_ADDR, 8'h03);
    sequencer_model_i.fire(IJ);
    rd(SELECT_ADDR, 8'h53);
    ij_en = 1'b1;
    sequencer_model_i.fire(IJ);
    rd(SELECT_ADDR, 8'h33);
    wr(MODE_ADDR, 8'hae);
    rd(MODE_ADDR, 8'ha6);
    ccr = 1'b1;
    @(negedge core_clk);
    check_out(16'(prog_addr_hi), 16'h0002);
    wr(MODE_ADDR, 8'h26);
    @(negedge core_clk);
    check_out(16'(prog_addr_hi), 16'h0003);
    ccr = 1'b0;
    sequencer_model_i.fire(IQ);
    rd(SELECT_ADDR, 8'h66);
    wr(SELECT_ADDR, 8'h04);
    sequencer_model_i.fire(CL);
    rd(SELECT_ADDR, 8'h44);
    sequencer_model_i.fire(RT);
    rd(SELECT_ADDR, 8'h64);
    sequencer_model_i.fire(RT);
    rd(SELECT_ADDR, 8'h33);
    // fill the stack to one short of its depth
    for (int i = 1; i <= 31; i++)
    begin
      sequencer_model_i.fire(CL);
      if (i == 30)
        rd(MODE_ADDR, 8'h26);
    end
    rd(MODE_ADDR, 8'h2e);
    sequencer_model_i.fire(RT);
    rd(MODE_ADDR, 8'h26);
    // second reset in mid-run
    srst = 1'b1;
    repeat (2) @(negedge core_clk);
    srst = 1'b0;
    rd(MODE_ADDR, 8'h00);
    rd(SELECT_ADDR, 8'h00);
    // a return on an empty stack is ignored, then a call and return back to back
    wr(SELECT_ADDR, 8'h02);
    sequencer_model_i.fire(RT);
    rd(SELECT_ADDR, 8'h02);
    sequencer_model_i.fire_pair(CL, RT);
    rd(SELECT_ADDR, 8'h02);
    check_out(16'(prog_addr_hi), 16'h0000);
    wr(SELECT_ADDR, 8'h07);
    wr(MODE_ADDR, 8'h77);
    sequencer_model_i.fire(LJ);
    rd(SELECT_ADDR, 8'h77);
    check_out(16'(port_four_pin), 16'h0003);
    latch(2'h0, 2'h0);
    latch(2'h2, 2'h2);
    rd(8'h96, 8'h00);
    complete_run();
  end
endmodule
